/* tcw_pkg.sv */
package tcw_pkg;

  // ==========================================
  // register map
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_MODE    = 8'h04;
  localparam logic [7:0] OFF_COUNTER = 8'h10;
  localparam logic [7:0] OFF_CMP_A   = 8'h14;
  localparam logic [7:0] OFF_CMP_B   = 8'h18;
  localparam logic [7:0] OFF_CMP_C   = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [15:0] CMP_RESET  = 16'h0000;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;

  // ==========================================
  // command register bits
  localparam int CMD_ON_BIT   = 0;
  localparam int CMD_OFF_BIT  = 1;
  localparam int CMD_SOFT_BIT = 2;

  // ==========================================
  // status register bits
  localparam int STS_CLK_BIT   = 16;
  localparam int STS_LINEA_BIT = 17;
  localparam int STS_LINEB_BIT = 18;

  // ==========================================
  // clock source codes and prescaler taps
  localparam logic [2:0] CLK_EXT0 = 3'h5;
  localparam int         PSC_W    = 10;
  localparam int         TAP_DIV2    = 0;
  localparam int         TAP_DIV8    = 2;
  localparam int         TAP_DIV32   = 4;
  localparam int         TAP_DIV128  = 6;
  localparam int         TAP_DIV1024 = 9;

  // ==========================================
  // field encodings
  localparam logic [1:0] GATE_NONE   = 2'h0;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_FALL   = 2'h2;
  localparam logic [1:0] EDGE_BOTH   = 2'h3;
  localparam logic [1:0] EVT_LINE_B  = 2'h0;
  localparam logic [1:0] ACT_SET     = 2'h1;
  localparam logic [1:0] ACT_CLEAR   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE  = 2'h3;

  // ==========================================
  // mode register layout, msb first
  typedef struct packed {
    logic [1:0] line_b_on_soft_trigger;
    logic [1:0] line_b_on_event;
    logic [1:0] line_b_on_c_match;
    logic [1:0] line_b_on_b_match;
    logic [1:0] line_a_on_soft_trigger;
    logic [1:0] line_a_on_event;
    logic [1:0] line_a_on_c_match;
    logic [1:0] line_a_on_a_match;
    logic       wave;
    logic       c_match_trigger_enable;
    logic       rsvd;
    logic       event_trigger_enable;
    logic [1:0] event_signal_select;
    logic [1:0] event_edge_select;
    logic       disable_on_c_match;
    logic       stop_on_c_match;
    logic [1:0] gate_select;
    logic       count_edge_invert;
    logic [2:0] count_clock_select;
  } tcw_mode_t;

endpackage : tcw_pkg

/* tcw_channel.sv */
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
// Behaviour
// - clock select: master taps or external clocks
// - invert bit picks counting edge
// - gate field ANDs external clock in
// - stop counter clock at compare C, waveform mode only
// - disable counter clock at compare C, waveform mode only
// - event edge: none, rise, fall, both
// - event source: line B or externals
// - line B input when it is source
// - event trigger resets and starts counter, waveform mode only
// - C match trigger resets and starts counter
// - bit 15 selects waveform mode
// - A match action on line A
// - C match action on line A
// - event action on line A
// - soft trigger action on line A
// - B match action on line B
// - C match action on line B
// - event action on line B
// - soft trigger action on line B
// - counter value readable, upper bits zero
// - compare A writable only in waveform mode
// - soft trigger resets and starts counter
// - off command beats on command
module tcw_channel
  import tcw_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // external clocks
  input  wire logic        extClockZero,
  input  wire logic        extClockOne,
  input  wire logic        extClockTwo,
  // channel lines
  output logic             ioLineAOut,
  output logic             ioLineAOe,
  input  wire logic        ioLineBIn,
  output logic             ioLineBOut,
  output logic             ioLineBOe
);

  // ==========================================
  // line action helper
  function automatic logic applyAct(input logic cur, input logic [1:0] act, input logic ev);
    logic res;
    res = cur;
    if (ev) begin
      unique case (act)
        ACT_SET:    res = 1'b1;
        ACT_CLEAR:  res = 1'b0;
        ACT_TOGGLE: res = ~cur;
        default:    res = cur;
      endcase
    end
    return res;
  endfunction : applyAct

  // ==========================================
  // input synchronisers
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
    end else begin
      syncA_q <= {ioLineBIn, extClockTwo, extClockOne, extClockZero};
      syncB_q <= syncA_q;
    end
  end
  logic [2:0] extClk;
  logic       lineBPin;
  assign extClk   = syncB_q[2:0];
  assign lineBPin = syncB_q[3];

  // ==========================================
  // bus slave
  tcw_mode_t   mode_q;
  logic [15:0] cnt_q;
  logic [15:0] cmpA_q;
  logic [15:0] cmpB_q;
  logic [15:0] cmpC_q;
  logic        count_clock_on_cmd_q;
  logic        clkRun_q;
  logic        lineA_q;
  logic        lineB_q;
  logic        wrPend_q;
  logic [7:0]  wrAddr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        addrOk;
  logic        doWrite;
  logic        cmdOn;
  logic        cmdOff;
  logic        cmdSoft;
  logic [31:0] rdMux;

  assign addrOk  = hsel && htrans[1] && hready;
  assign doWrite = wrPend_q;
  assign cmdOn   = doWrite && wrAddr_q == OFF_COMMAND && hwdata[CMD_ON_BIT];
  assign cmdOff  = doWrite && wrAddr_q == OFF_COMMAND && hwdata[CMD_OFF_BIT];
  assign cmdSoft = doWrite && wrAddr_q == OFF_COMMAND && hwdata[CMD_SOFT_BIT];

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr[7:0])
      OFF_MODE:    rdMux = mode_q;
      OFF_COUNTER: rdMux = {16'h0000, cnt_q};
      OFF_CMP_A:   rdMux = {16'h0000, cmpA_q};
      OFF_CMP_B:   rdMux = {16'h0000, cmpB_q};
      OFF_CMP_C:   rdMux = {16'h0000, cmpC_q};
      OFF_STATUS: begin
        rdMux[STS_CLK_BIT]   = count_clock_on_cmd_q;
        rdMux[STS_LINEA_BIT] = lineA_q;
        rdMux[STS_LINEB_BIT] = mode_q.event_signal_select == EVT_LINE_B ? lineBPin : lineB_q;
      end
      default:     rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPend_q    <= 1'b0;
      wrAddr_q    <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      wrPend_q    <= addrOk && hwrite;
      if (addrOk) begin
        wrAddr_q <= haddr[7:0];
      end
      if (addrOk && !hwrite) begin
        hrdata_q <= (haddr[31:8] == 24'h000000) ? rdMux : 32'h0000_0000;
      end
    end
  end
  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= MODE_RESET;
      cmpA_q <= CMP_RESET;
      cmpB_q <= CMP_RESET;
      cmpC_q <= CMP_RESET;
    end else if (doWrite) begin
      unique case (wrAddr_q)
        OFF_MODE:  mode_q <= hwdata;
        OFF_CMP_A: if (mode_q.wave) cmpA_q <= hwdata[15:0];
        OFF_CMP_B: if (mode_q.wave) cmpB_q <= hwdata[15:0];
        OFF_CMP_C: cmpC_q <= hwdata[15:0];
        default:   ;
      endcase
    end
  end

  // ==========================================
  // counter clock source
  logic [PSC_W-1:0] psc_q;
  logic             srcLvl;
  logic             gateLvl;
  logic             cntLvl;
  logic             cntLvl_q;
  logic             tick;
  always_ff @(posedge clock) begin
    if (!rst_n) psc_q <= '0;
    else psc_q <= psc_q + 1'b1;
  end

  always_comb begin
    unique case (mode_q.count_clock_select)
      3'h0:    srcLvl = psc_q[TAP_DIV2];
      3'h1:    srcLvl = psc_q[TAP_DIV8];
      3'h2:    srcLvl = psc_q[TAP_DIV32];
      3'h3:    srcLvl = psc_q[TAP_DIV128];
      3'h4:    srcLvl = psc_q[TAP_DIV1024];
      default: srcLvl = extClk[2'(mode_q.count_clock_select - CLK_EXT0)];
    endcase
    gateLvl = (mode_q.gate_select == GATE_NONE) ? 1'b1
            : extClk[2'(mode_q.gate_select - 2'h1)];
    cntLvl  = (srcLvl & gateLvl) ^ mode_q.count_edge_invert;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) cntLvl_q <= 1'b0;
    else cntLvl_q <= cntLvl;
  end
  assign tick = cntLvl && !cntLvl_q;

  // ==========================================
  // external event detect
  logic evtLvl;
  logic evtLvl_q;
  logic evtRise;
  logic evtFall;
  logic evt;
  assign evtLvl = (mode_q.event_signal_select == EVT_LINE_B) ? lineBPin
                : extClk[2'(mode_q.event_signal_select - 2'h1)];
  always_ff @(posedge clock) begin
    if (!rst_n) evtLvl_q <= 1'b0;
    else evtLvl_q <= evtLvl;
  end
  assign evtRise = evtLvl && !evtLvl_q;
  assign evtFall = !evtLvl && evtLvl_q;
  assign evt = mode_q.wave && (
      (mode_q.event_edge_select == EDGE_RISE && evtRise) ||
      (mode_q.event_edge_select == EDGE_FALL && evtFall) ||
      (mode_q.event_edge_select == EDGE_BOTH && (evtRise || evtFall)));

  // ==========================================
  // counter and compares
  logic        advance;
  logic [15:0] cntInc;
  logic        hitA;
  logic        hitB;
  logic        hitC;
  logic        evtTrig;
  logic        cTrig;
  logic        trig;
  logic        stopC;
  logic        disC;
  assign advance = tick && count_clock_on_cmd_q && clkRun_q;
  assign cntInc  = cnt_q + 16'h0001;
  assign hitA    = advance && mode_q.wave && cntInc == cmpA_q;
  assign hitB    = advance && mode_q.wave && cntInc == cmpB_q;
  assign hitC    = advance && cntInc == cmpC_q;
  assign evtTrig = evt && mode_q.event_trigger_enable;
  assign cTrig   = hitC && mode_q.c_match_trigger_enable;
  assign trig    = cmdSoft || evtTrig || cTrig;
  assign stopC   = hitC && mode_q.wave && mode_q.stop_on_c_match;
  assign disC    = hitC && mode_q.wave && mode_q.disable_on_c_match;

  always_ff @(posedge clock) begin
    if (!rst_n) cnt_q <= CNT_RESET;
    else if (trig) cnt_q <= CNT_RESET;
    else if (advance) cnt_q <= cntInc;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) count_clock_on_cmd_q <= 1'b0;
    else if (cmdOff) count_clock_on_cmd_q <= 1'b0;
    else if (cmdOn) count_clock_on_cmd_q <= 1'b1;
    else if (disC) count_clock_on_cmd_q <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) clkRun_q <= 1'b0;
    else if (cmdSoft || evtTrig || cmdOn) clkRun_q <= 1'b1;
    else if (stopC) clkRun_q <= 1'b0;
    else if (cTrig) clkRun_q <= 1'b1;
  end

  // ==========================================
  // output lines
  logic lineAD;
  logic lineBD;
  always_comb begin
    // later steps override earlier: soft trigger wins
    lineAD = applyAct(lineA_q, mode_q.line_a_on_a_match, hitA);
    lineAD = applyAct(lineAD, mode_q.line_a_on_c_match, hitC && mode_q.wave);
    lineAD = applyAct(lineAD, mode_q.line_a_on_event, evt);
    lineAD = applyAct(lineAD, mode_q.line_a_on_soft_trigger,
                      cmdSoft && mode_q.wave);
    lineBD = applyAct(lineB_q, mode_q.line_b_on_b_match, hitB);
    lineBD = applyAct(lineBD, mode_q.line_b_on_c_match, hitC && mode_q.wave);
    lineBD = applyAct(lineBD, mode_q.line_b_on_event, evt);
    lineBD = applyAct(lineBD, mode_q.line_b_on_soft_trigger,
                      cmdSoft && mode_q.wave);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lineA_q   <= 1'b0;
      lineB_q   <= 1'b0;
      ioLineAOe <= 1'b0;
      ioLineBOe <= 1'b0;
    end else begin
      lineA_q   <= lineAD;
      lineB_q   <= lineBD;
      ioLineAOe <= mode_q.wave;
      ioLineBOe <= mode_q.wave && mode_q.event_signal_select != EVT_LINE_B;
    end
  end
  assign ioLineAOut = lineA_q;
  assign ioLineBOut = lineB_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seqSoft;
    cmdSoft;
  endsequence

  sequence seqPlainStep;
    advance && !trig;
  endsequence

  sequence seqStopAtC;
    stopC && !cmdSoft && !evtTrig && !cmdOn;
  endsequence

  chk_soft_reset: assert property (seqSoft |=> cnt_q == CNT_RESET)
    else $error("soft trigger did not clear counter");

  chk_off_wins: assert property (cmdOff |=> !count_clock_on_cmd_q)
    else $error("off command did not disable clock");

  chk_on_enables: assert property (cmdOn && !cmdOff |=> count_clock_on_cmd_q && clkRun_q)
    else $error("on command did not enable clock");

  chk_stop_at_c: assert property (seqStopAtC |=> !clkRun_q ##1 (cnt_q == $past(cnt_q)))
    else $error("counter kept running after stop at C");

  chk_disable_c: assert property (disC && !cmdOn |=> !count_clock_on_cmd_q)
    else $error("clock not disabled at C");

  chk_count_step: assert property (seqPlainStep |=> cnt_q == $past(cntInc))
    else $error("counter did not step by one");

  chk_wrap_zero: assert property (seqPlainStep and cnt_q == CNT_MAX |=> cnt_q == CNT_RESET)
    else $error("counter did not wrap");

  chk_event_trig: assert property (evtTrig |=> cnt_q == CNT_RESET && clkRun_q)
    else $error("event trigger did not restart counter");

  chk_c_trig: assert property (cTrig |=> cnt_q == CNT_RESET)
    else $error("C match trigger did not clear counter");

  chk_line_b_input: assert property (
    mode_q.event_signal_select == EVT_LINE_B |=> !ioLineBOe)
    else $error("line B driven while used as input");

  chk_soft_line_a: assert property (
    cmdSoft && mode_q.wave && mode_q.line_a_on_soft_trigger == ACT_SET
    |=> ioLineAOut)
    else $error("soft trigger did not set line A");

  chk_cmp_a_locked: assert property (
    doWrite && wrAddr_q == OFF_CMP_A && !mode_q.wave |=> $stable(cmpA_q))
    else $error("compare A written in capture mode");

endmodule : tcw_channel

/* tcw_line_partner.sv */
`timescale 1ns/10ps
module tcw_line_partner (
  // clock
  input  wire logic       clock,
  // line b from the channel
  input  wire logic       lineBOut,
  input  wire logic       lineBOe,
  // bench control
  input  wire logic       pinDrive,
  input  wire logic [2:0] extRun,
  // towards the channel
  output logic            lineBIn,
  output logic [2:0]      extClock
);
  logic [1:0] divQ = 2'h0;

  // ==========================================
  // resolved line b level
  assign lineBIn = lineBOe ? lineBOut : pinDrive;

  // ==========================================
  // external clocks, period 8, level held when stopped
  initial extClock = 3'h0;
  always @(posedge clock) begin
    divQ <= divQ + 2'h1;
    for (int i = 0; i < 3; i++) begin
      if (extRun[i] === 1'b1 && divQ == 2'h3) extClock[i] <= ~extClock[i];
    end
  end
endmodule : tcw_line_partner

/* testbench.sv */
`timescale 1ns/10ps
module testbench
  import tcw_pkg::*;
;
  // ==========================================
  // bench signals
  logic        clock, rst_n, hsel, hwrite, hreadyout, hresp, pinDrive;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, v, w;
  logic [2:0]  extRun, extClock;
  logic        ioLineAOut, ioLineAOe, ioLineBIn, ioLineBOut, ioLineBOe, a0, b0;
  tcw_mode_t   m;
  int          mismatches, check_count;

  tcw_channel tcw_channel_i (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .extClockZero(extClock[0]), .extClockOne(extClock[1]),
    .extClockTwo(extClock[2]), .ioLineAOut(ioLineAOut), .ioLineAOe(ioLineAOe),
    .ioLineBIn(ioLineBIn), .ioLineBOut(ioLineBOut), .ioLineBOe(ioLineBOe)
  );
  tcw_line_partner tcw_line_partner_i (
    .clock(clock), .lineBOut(ioLineBOut), .lineBOe(ioLineBOe),
    .pinDrive(pinDrive), .extRun(extRun), .lineBIn(ioLineBIn),
    .extClock(extClock)
  );

  // ==========================================
  // report and compare
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chb

  // ==========================================
  // ahb-lite master
  task automatic hw();
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        $display("[FAIL] %0t bus wait ran out", $time);
        mismatches++;
        results();
      end
      @(posedge clock);
    end
  endtask : hw
  task automatic ap(input logic [7:0] a, input logic wrt);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wrt;
    hw();
    hsel   <= 1'b0;
    htrans <= 2'h0;
  endtask : ap
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ap(a, 1'b1);
    hwdata <= d;
    hw();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ap(a, 1'b0);
    hw();
    d = hrdata;
  endtask : rd

  // ==========================================
  // helpers: count step over 64 cycles, line levels
  task automatic rate(input logic [31:0] exp);
    rd(OFF_COUNTER, v);
    repeat (61) @(posedge clock);
    rd(OFF_COUNTER, w);
    chk(w - v, exp);
    chk(w & 32'hffff_0000, 32'h0);
  endtask : rate
  task automatic lines(input logic a, input logic b);
    repeat (3) @(posedge clock);
    #1;
    chb(ioLineAOut, a);
    chb(ioLineBOut, b);
  endtask : lines
  // cycles until line a next changes, bounded
  task automatic edgeWait(output int n);
    logic s;
    #1;
    s = ioLineAOut;
    n = 0;
    while (ioLineAOut === s && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : edgeWait
  // run external clock zero until it shows lvl, then hold it
  task automatic hold(input logic lvl);
    int n;
    n = 0;
    extRun <= 3'h1;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (extClock[0] !== lvl && n < 20);
    extRun <= 3'h0;
    if (extClock[0] !== lvl) begin
      $display("[FAIL] %0t external clock stuck", $time);
      mismatches++;
    end
    repeat (8) @(posedge clock);
  endtask : hold

  // ==========================================
  // scenarios
  task automatic t_reset();
    chb(ioLineAOe, 1'b0);
    chb(hresp, 1'b0);
    rd(OFF_MODE, v);
    chk(v, MODE_RESET);
    rd(OFF_COUNTER, v);
    chk(v, {16'h0, CNT_RESET});
    wr(OFF_CMP_A, 32'h1234_abcd);
    rd(OFF_CMP_A, v);
    chk(v, {16'h0, CMP_RESET});
    rd(8'h3c, v);
    chk(v, 32'h0);
    m = '0;
    m.wave = 1'b1;
    m.event_signal_select = 2'h1;
    wr(OFF_MODE, m);
    rd(OFF_MODE, v);
    chk(v, m);
    chb(ioLineAOe, 1'b1);
    wr(OFF_CMP_A, 32'h1234_abcd);
    rd(OFF_CMP_A, v);
    chk(v, 32'h0000_abcd);
    $display("test reset and compare a done");
  endtask : t_reset
  task automatic t_count();
    wr(OFF_COMMAND, 32'h3);
    rate(32'h0);
    wr(OFF_COMMAND, 32'h1);
    for (int i = 0; i < 3; i++) begin
      m.count_clock_select = 3'(i);
      wr(OFF_MODE, m);
      rate(32'h20 >> (2 * i));
    end
    wr(OFF_COMMAND, 32'h2);
    wr(OFF_COMMAND, 32'h4);
    repeat (4) @(posedge clock);
    rd(OFF_COUNTER, v);
    chk(v, 32'h0);
    $display("test counting done");
  endtask : t_count
  task automatic t_soft();
    logic [1:0] acts [5];
    logic [4:0] lvl;
    acts = '{ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_CLEAR, 2'h0};
    lvl = 5'b00101;
    for (int i = 0; i < 5; i++) begin
      m.line_a_on_soft_trigger = acts[i];
      m.line_b_on_soft_trigger = acts[i];
      wr(OFF_MODE, m);
      wr(OFF_COMMAND, 32'h4);
      lines(lvl[i], lvl[i]);
    end
    chb(ioLineBOe, 1'b1);
    $display("test soft trigger lines done");
  endtask : t_soft
  task automatic t_cmatch();
    int n;
    m = '0;
    m.wave = 1'b1;
    m.event_signal_select = 2'h1;
    m.c_match_trigger_enable = 1'b1;
    m.line_a_on_c_match = ACT_TOGGLE;
    m.line_b_on_c_match = ACT_TOGGLE;
    wr(OFF_CMP_C, 32'ha);
    wr(OFF_MODE, m);
    wr(OFF_COMMAND, 32'h5);
    for (int i = 0; i < 4; i++) begin
      repeat (7) @(posedge clock);
      rd(OFF_COUNTER, v);
      chb(v < 32'ha, 1'b1);
    end
    // period is compare c times the divide-by-2 tap
    edgeWait(n);
    for (int i = 0; i < 2; i++) begin
      a0 = ioLineAOut;
      b0 = ioLineBOut;
      edgeWait(n);
      chk(n, 32'ha * 2);
      chb(ioLineAOut, ~a0);
      chb(ioLineBOut, ~b0);
    end
    // set at compare a and b, clear at compare c
    wr(OFF_CMP_A, 32'h4);
    wr(OFF_CMP_B, 32'h4);
    m.line_a_on_a_match = ACT_SET;
    m.line_a_on_c_match = ACT_CLEAR;
    m.line_b_on_b_match = ACT_SET;
    m.line_b_on_c_match = ACT_CLEAR;
    wr(OFF_MODE, m);
    edgeWait(n);
    edgeWait(n);
    chk(n, ioLineAOut ? 32'h4 * 2 : (32'ha - 32'h4) * 2);
    chb(ioLineBOut, ioLineAOut);
    $display("test c match trigger done");
  endtask : t_cmatch
  task automatic t_stop();
    wr(OFF_COMMAND, 32'h2);
    m = '0;
    m.wave = 1'b1;
    m.event_signal_select = 2'h1;
    m.stop_on_c_match = 1'b1;
    m.disable_on_c_match = 1'b1;
    wr(OFF_CMP_C, 32'h5);
    wr(OFF_MODE, m);
    wr(OFF_COMMAND, 32'h5);
    repeat (40) @(posedge clock);
    rd(OFF_COUNTER, v);
    chk(v, 32'h5);
    rd(OFF_STATUS, v);
    chb(v[STS_CLK_BIT], 1'b0);
    $display("test stop and disable done");
  endtask : t_stop
  task automatic t_event();
    m = '0;
    m.wave = 1'b1;
    m.event_signal_select = EVT_LINE_B;
    m.event_edge_select = EDGE_RISE;
    m.event_trigger_enable = 1'b1;
    m.line_a_on_event = ACT_TOGGLE;
    m.line_b_on_event = ACT_TOGGLE;
    wr(OFF_MODE, m);
    repeat (8) @(posedge clock);
    #1;
    chb(ioLineBOe, 1'b0);
    a0 = ioLineAOut;
    b0 = ioLineBOut;
    @(posedge clock);
    pinDrive <= 1'b1;
    lines(~a0, ~b0);
    repeat (8) @(posedge clock);
    rd(OFF_COUNTER, v);
    chk(v, 32'h0);
    @(posedge clock);
    pinDrive <= 1'b0;
    repeat (8) @(posedge clock);
    lines(~a0, ~b0);
    m.event_edge_select = EDGE_BOTH;
    wr(OFF_MODE, m);
    @(posedge clock);
    pinDrive <= 1'b1;
    lines(a0, b0);
    @(posedge clock);
    pinDrive <= 1'b0;
    lines(~a0, ~b0);
    $display("test external event done");
  endtask : t_event
  task automatic t_ext();
    @(posedge clock);
    extRun <= 3'h1;
    m = '0;
    m.wave = 1'b1;
    m.event_signal_select = 2'h1;
    m.count_clock_select = CLK_EXT0;
    wr(OFF_MODE, m);
    wr(OFF_COMMAND, 32'h1);
    rate(32'h8);
    m.gate_select = 2'h2;
    wr(OFF_MODE, m);
    rate(32'h0);
    // inverted: only the falling edge counts
    m.gate_select = GATE_NONE;
    m.count_edge_invert = 1'b1;
    wr(OFF_MODE, m);
    hold(1'b1);
    rd(OFF_COUNTER, v);
    hold(1'b0);
    rd(OFF_COUNTER, w);
    chk(w - v, 32'h1);
    hold(1'b1);
    rd(OFF_COUNTER, v);
    chk(v - w, 32'h0);
    $display("test external clock done");
  endtask : t_ext

  // ==========================================
  // clock and main sequence
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rst_n, hsel, hwrite, pinDrive} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    extRun = 3'h0;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_count();
    t_soft();
    t_cmatch();
    t_stop();
    t_event();
    t_ext();
    results();
  end
endmodule : testbench
